// *** shared/smp_pkg.sv ***
// constants, register map and types shared by the status map parameter table block
package smp_pkg;

    // status register 1 bit positions
    localparam int unsigned SR1_BUSY_POS  = 0;
    localparam int unsigned SR1_WEL_POS   = 1;
    localparam int unsigned SR1_PFAIL_POS = 6;

    // serial command opcodes
    localparam logic [7:0] CMD_WEL_SET   = 8'h06;
    localparam logic [7:0] CMD_SR_READ   = 8'h05;
    localparam logic [7:0] CMD_ADDR_READ = 8'h65;

    // addressed register read framing
    localparam logic [1:0]  ADDR_BYTES_M1  = 2'h2;
    localparam logic [1:0]  DUMMY_BYTES_M1 = 2'h0;
    localparam logic [23:0] SR1_REG_ADDR   = 24'h000000;
    localparam logic [2:0]  LAST_BIT       = 3'h7;

    // apb byte offsets of the block's own registers
    localparam logic [11:0] EVT_STATUS_OFS = 12'h000;
    localparam logic [11:0] EVT_MASK_OFS   = 12'h004;
    localparam logic [11:0] FLAG_STATE_OFS = 12'h008;

    // parameter table register indices; byte address is four times the index
    localparam logic [9:0] PROGRESS_FLAG_DESCRIPTOR_IDX   = 10'h17F;
    localparam logic [9:0] LATCH_WRITE_OPCODE_IDX         = 10'h180;
    localparam logic [9:0] LATCH_READ_OPCODE_IDX          = 10'h181;
    localparam logic [9:0] LATCH_REGISTER_ADDRESS_IDX     = 10'h182;
    localparam logic [9:0] LATCH_DESCRIPTOR_IDX           = 10'h183;
    localparam logic [9:0] PROG_FAIL_WRITE_OPCODE_IDX     = 10'h184;
    localparam logic [9:0] PROG_FAIL_READ_OPCODE_IDX      = 10'h185;
    localparam logic [9:0] PROG_FAIL_REGISTER_ADDRESS_IDX = 10'h186;
    localparam logic [9:0] PROG_FAIL_DESCRIPTOR_IDX       = 10'h187;

    // parameter table contents
    localparam logic [7:0] PROGRESS_FLAG_DESCRIPTOR_VAL   = 8'h90;
    localparam logic [7:0] LATCH_WRITE_OPCODE_VAL         = 8'h06;
    localparam logic [7:0] LATCH_READ_OPCODE_VAL          = 8'h05;
    localparam logic [7:0] LATCH_REGISTER_ADDRESS_VAL     = 8'h00;
    localparam logic [7:0] LATCH_DESCRIPTOR_VAL           = 8'hA1;
    localparam logic [7:0] PROG_FAIL_WRITE_OPCODE_VAL     = 8'h00;
    localparam logic [7:0] PROG_FAIL_READ_OPCODE_VAL      = 8'h65;
    localparam logic [7:0] PROG_FAIL_REGISTER_ADDRESS_VAL = 8'h00;
    localparam logic [7:0] PROG_FAIL_DESCRIPTOR_VAL       = 8'h96;

    // event bits of the status and mask registers
    localparam int unsigned EVT_WEL_SET = 0;
    localparam int unsigned EVT_DONE    = 1;
    localparam int unsigned EVT_PFAIL   = 2;
    localparam int unsigned EVT_W       = 3;

    // synchroniser lanes
    localparam int unsigned SYN_SCLK = 0;
    localparam int unsigned SYN_CS   = 1;
    localparam int unsigned SYN_MOSI = 2;
    localparam int unsigned SYN_W    = 3;

    // serial command decoder states
    typedef enum logic [2:0] {SPI_CMD, SPI_ADDR, SPI_DUMMY, SPI_DATA, SPI_SKIP} smp_spi_state_type;

endpackage

// *** rtl/smp_top.sv ***
// status map parameter table: serial status commands, status register 1 and apb view
//
// Functional notes
// - busy flag sits at status bit 0; descriptor position field reads 000.
// - busy reads 1 during internal write; descriptor shows active high, supported.
// - busy descriptor shows addressed set/clear, bit 27 unsupported.
// - opcode 06h sets the write permit latch; host sends it before modifying.
// - opcode 05h returns the register holding the write permit latch.
// - write permit latch lives in volatile status register 1, address 00h.
// - write permit latch occupies status bit 1, position field 001.
// - write permit latch is set by a dedicated direct command.
// - latch descriptor shows supported, active high, not in last address byte.
// - register holding program error accepts no direct write command.
// - opcode 65h addressed read returns the register holding program error.
// - program error lives in status register 1 at register address 00h.
// - program error reads 1 after a failed program, else 0.
// - program error sits at status bit 6, position field 110.
// - program error descriptor shows addressed set/clear, no separate bits.
// - addressed register reads take a three byte register address.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module smp_top
    import smp_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial flash pins
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe_n,
    // array engine side
    input  wire logic        array_busy,
    input  wire logic        array_prog_fail,
    output logic             write_permit_latch,
    // interrupt
    output logic             irq
);

    // synchroniser and edge history
    logic [SYN_W-1:0]  syn1_r;
    logic [SYN_W-1:0]  syn2_r;
    logic              sclk_d_r;
    logic              sclk_s;
    logic              cs_n_s;
    logic              mosi_s;
    logic              sclk_rise;
    logic              sclk_fall;

    // serial decoder state
    smp_spi_state_type state_r;
    smp_spi_state_type state_nxt;
    logic [2:0]        bit_cnt_r;
    logic [2:0]        bit_cnt_nxt;
    logic [1:0]        byte_cnt_r;
    logic [1:0]        byte_cnt_nxt;
    logic [7:0]        rx_r;
    logic [7:0]        rx_nxt;
    logic [7:0]        tx_r;
    logic [7:0]        tx_nxt;
    logic [23:0]       addr_r;
    logic [23:0]       addr_nxt;
    logic              miso_r;
    logic              miso_nxt;
    logic              oe_n_r;
    logic              oe_n_nxt;
    logic [7:0]        rx_byte;
    logic [7:0]        reply_byte;
    logic              wel_cmd;

    // flags and events
    logic              wel_r;
    logic              wel_nxt;
    logic              busy_d_r;
    logic              pfail_d_r;
    logic              busy_fall;
    logic              pfail_rise;
    logic [7:0]        sr1;
    logic [EVT_W-1:0]  evt_set;
    logic [EVT_W-1:0]  evt_status_r;
    logic [EVT_W-1:0]  evt_status_nxt;
    logic [EVT_W-1:0]  evt_mask_r;
    logic [EVT_W-1:0]  evt_mask_nxt;
    logic              irq_r;
    logic              irq_nxt;

    // apb slave state
    logic              pready_r;
    logic              pready_nxt;
    logic              pslverr_r;
    logic              pslverr_nxt;
    logic [31:0]       prdata_r;
    logic [31:0]       prdata_nxt;
    logic              apb_fire;
    logic              apb_wr;
    logic [9:0]        apb_idx;

    // pins come from the host's clock domain: two flops before any logic
    genvar gi;
    generate
        for (gi = 0; gi < SYN_W; gi++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    syn1_r[gi] <= (gi == SYN_CS) ? 1'b1 : 1'b0;
                    syn2_r[gi] <= (gi == SYN_CS) ? 1'b1 : 1'b0;
                end
                else
                begin
                    syn1_r[gi] <= (gi == SYN_SCLK) ? spi_sclk : (gi == SYN_CS) ? spi_cs_n : spi_mosi;
                    syn2_r[gi] <= syn1_r[gi];
                end
            end
        end
    endgenerate

    // edge detection works only on the second synchroniser stage
    assign sclk_s    = syn2_r[SYN_SCLK];
    assign cs_n_s    = syn2_r[SYN_CS];
    assign mosi_s    = syn2_r[SYN_MOSI];
    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign sclk_fall = ~sclk_s & sclk_d_r;
    assign rx_byte   = {rx_r[6:0], mosi_s};

    // status register 1 image, unused bits read zero
    always_comb
    begin
        sr1 = 8'h00;
        sr1[SR1_BUSY_POS] = array_busy;
        sr1[SR1_WEL_POS] = wel_r;
        sr1[SR1_PFAIL_POS] = array_prog_fail;
    end

    assign reply_byte = (addr_r == SR1_REG_ADDR) ? sr1 : 8'h00;

    // serial decoder: mode 0, sample on rising sclk, shift out on falling sclk
    always_comb
    begin
        state_nxt    = state_r;
        bit_cnt_nxt  = bit_cnt_r;
        byte_cnt_nxt = byte_cnt_r;
        rx_nxt       = rx_r;
        tx_nxt       = tx_r;
        addr_nxt     = addr_r;
        miso_nxt     = miso_r;
        oe_n_nxt     = oe_n_r;
        wel_cmd      = 1'b0;
        if (cs_n_s)
        begin
            // deselect aborts any frame and releases the data pin
            state_nxt    = SPI_CMD;
            bit_cnt_nxt  = 3'h0;
            byte_cnt_nxt = 2'h0;
            addr_nxt     = SR1_REG_ADDR;
            miso_nxt     = 1'b0;
            oe_n_nxt     = 1'b1;
        end
        else if (sclk_rise)
        begin
            rx_nxt      = rx_byte;
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (bit_cnt_r == LAST_BIT)
            begin
                case (state_r)
                    SPI_CMD:
                    begin
                        case (rx_byte)
                            CMD_WEL_SET:
                            begin
                                wel_cmd   = 1'b1;
                                state_nxt = SPI_SKIP;
                            end
                            CMD_SR_READ:
                            begin
                                tx_nxt    = sr1;
                                state_nxt = SPI_DATA;
                            end
                            CMD_ADDR_READ:
                            begin
                                byte_cnt_nxt = 2'h0;
                                state_nxt    = SPI_ADDR;
                            end
                            default:
                            begin
                                state_nxt = SPI_SKIP;
                            end
                        endcase
                    end
                    SPI_ADDR:
                    begin
                        addr_nxt     = {addr_r[15:0], rx_byte};
                        byte_cnt_nxt = byte_cnt_r + 2'h1;
                        if (byte_cnt_r == ADDR_BYTES_M1)
                        begin
                            byte_cnt_nxt = 2'h0;
                            state_nxt    = SPI_DUMMY;
                        end
                    end
                    SPI_DUMMY:
                    begin
                        byte_cnt_nxt = byte_cnt_r + 2'h1;
                        if (byte_cnt_r == DUMMY_BYTES_M1)
                        begin
                            tx_nxt    = reply_byte;
                            state_nxt = SPI_DATA;
                        end
                    end
                    // reload each byte so the host sees live flags while polling
                    SPI_DATA:
                    begin
                        tx_nxt = reply_byte;
                    end
                    SPI_SKIP:
                    begin
                        state_nxt = SPI_SKIP;
                    end
                    default:
                    begin
                        state_nxt = SPI_SKIP;
                    end
                endcase
            end
        end
        else if (sclk_fall && (state_r == SPI_DATA))
        begin
            miso_nxt = tx_r[7];
            tx_nxt   = {tx_r[6:0], 1'b0};
            oe_n_nxt = 1'b0;
        end
    end

    // serial decoder registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_d_r   <= 1'b0;
            state_r    <= SPI_CMD;
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 2'h0;
            rx_r       <= 8'h00;
            tx_r       <= 8'h00;
            addr_r     <= SR1_REG_ADDR;
            miso_r     <= 1'b0;
            oe_n_r     <= 1'b1;
        end
        else
        begin
            sclk_d_r   <= sclk_s;
            state_r    <= state_nxt;
            bit_cnt_r  <= bit_cnt_nxt;
            byte_cnt_r <= byte_cnt_nxt;
            rx_r       <= rx_nxt;
            tx_r       <= tx_nxt;
            addr_r     <= addr_nxt;
            miso_r     <= miso_nxt;
            oe_n_r     <= oe_n_nxt;
        end
    end

    // latch, events and interrupt; array inputs share pclk so need no sync
    assign busy_fall  = busy_d_r & ~array_busy;
    assign pfail_rise = array_prog_fail & ~pfail_d_r;
    assign apb_fire   = psel & penable & pready_r;
    assign apb_wr     = apb_fire & pwrite;
    assign apb_idx    = paddr[11:2];

    always_comb
    begin
        evt_set              = '0;
        evt_set[EVT_WEL_SET] = wel_cmd;
        evt_set[EVT_DONE]    = busy_fall;
        evt_set[EVT_PFAIL]   = pfail_rise;
        // a finished internal write drops the latch; a new set command wins
        wel_nxt = wel_r;
        if (busy_fall)
        begin
            wel_nxt = 1'b0;
        end
        if (wel_cmd)
        begin
            wel_nxt = 1'b1;
        end
        // write one to clear, a same-cycle event still lands
        evt_status_nxt = evt_status_r;
        if (apb_wr && (paddr == EVT_STATUS_OFS))
        begin
            evt_status_nxt = evt_status_r & ~pwdata[EVT_W-1:0];
        end
        evt_status_nxt = evt_status_nxt | evt_set;
        evt_mask_nxt   = evt_mask_r;
        if (apb_wr && (paddr == EVT_MASK_OFS))
        begin
            evt_mask_nxt = pwdata[EVT_W-1:0];
        end
        irq_nxt = |(evt_status_nxt & evt_mask_nxt);
    end

    // flag and event registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wel_r        <= 1'b0;
            busy_d_r     <= 1'b0;
            pfail_d_r    <= 1'b0;
            evt_status_r <= '0;
            evt_mask_r   <= '0;
            irq_r        <= 1'b0;
        end
        else
        begin
            wel_r        <= wel_nxt;
            busy_d_r     <= array_busy;
            pfail_d_r    <= array_prog_fail;
            evt_status_r <= evt_status_nxt;
            evt_mask_r   <= evt_mask_nxt;
            irq_r        <= irq_nxt;
        end
    end

    // apb: one wait state, read data and error prepared with pready
    always_comb
    begin
        pready_nxt  = psel & penable & ~pready_r;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (pready_nxt)
        begin
            prdata_nxt = 32'h0000_0000;
            if (paddr[1:0] != 2'h0)
            begin
                pslverr_nxt = 1'b1;
            end
            else if (paddr == EVT_STATUS_OFS)
            begin
                prdata_nxt[EVT_W-1:0] = evt_status_r;
            end
            else if (paddr == EVT_MASK_OFS)
            begin
                prdata_nxt[EVT_W-1:0] = evt_mask_r;
            end
            else if (paddr == FLAG_STATE_OFS)
            begin
                prdata_nxt[7:0] = sr1;
                pslverr_nxt     = pwrite;
            end
            else
            begin
                // constant table bytes
                // writes to the table are refused and change nothing
                pslverr_nxt = pwrite;
                case (apb_idx)
                    PROGRESS_FLAG_DESCRIPTOR_IDX:   prdata_nxt[7:0] = PROGRESS_FLAG_DESCRIPTOR_VAL;
                    LATCH_WRITE_OPCODE_IDX:         prdata_nxt[7:0] = LATCH_WRITE_OPCODE_VAL;
                    LATCH_READ_OPCODE_IDX:          prdata_nxt[7:0] = LATCH_READ_OPCODE_VAL;
                    LATCH_REGISTER_ADDRESS_IDX:     prdata_nxt[7:0] = LATCH_REGISTER_ADDRESS_VAL;
                    LATCH_DESCRIPTOR_IDX:           prdata_nxt[7:0] = LATCH_DESCRIPTOR_VAL;
                    PROG_FAIL_WRITE_OPCODE_IDX:     prdata_nxt[7:0] = PROG_FAIL_WRITE_OPCODE_VAL;
                    PROG_FAIL_READ_OPCODE_IDX:      prdata_nxt[7:0] = PROG_FAIL_READ_OPCODE_VAL;
                    PROG_FAIL_REGISTER_ADDRESS_IDX: prdata_nxt[7:0] = PROG_FAIL_REGISTER_ADDRESS_VAL;
                    PROG_FAIL_DESCRIPTOR_IDX:       prdata_nxt[7:0] = PROG_FAIL_DESCRIPTOR_VAL;
                    default:                        pslverr_nxt     = 1'b1;
                endcase
            end
        end
    end

    // apb registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
        else
        begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // outputs straight from flops
    assign prdata             = prdata_r;
    assign pready             = pready_r;
    assign pslverr            = pslverr_r;
    assign spi_miso           = miso_r;
    assign spi_miso_oe_n      = oe_n_r;
    assign write_permit_latch = wel_r;
    assign irq                = irq_r;

endmodule
`default_nettype wire

// *** dv/smp_top_asserts.sv ***
// assertion checker for the status map parameter table top
`timescale 1ns/10ps
`default_nettype none
module smp_chk
    import smp_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // serial pins
    input wire logic        spi_cs_n,
    input wire logic        spi_miso,
    input wire logic        spi_miso_oe_n,
    // array side and interrupt
    input wire logic        array_busy,
    input wire logic        write_permit_latch,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // apb answer timing: one wait state, then a one cycle pulse
    AST_WAIT_STATE: assert property ($rose(penable) && psel |-> !pready ##1 pready ##1 !pready)
        else $error("pready not one cycle after access start");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_MISALIGNED: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    AST_UPPER_ZERO: assert property (pready && !pwrite && !pslverr |-> prdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");

    // table bytes stay fixed and refuse writes
    AST_TABLE_RO: assert property (pready && pwrite && paddr >= 12'h5FC && paddr <= 12'h61C |-> pslverr)
        else $error("table write not refused");
    AST_LATCH_OPCODE: assert property (pready && !pwrite && paddr == 12'h600 |-> prdata == 32'h00000006)
        else $error("latch write opcode byte wrong");
    AST_PFAIL_DESC: assert property (pready && !pwrite && paddr == 12'h61C |-> prdata == 32'h00000096)
        else $error("program error descriptor wrong");

    // serial output only while selected; idle level low
    AST_MISO_QUIET: assert property (spi_miso_oe_n |-> !spi_miso)
        else $error("miso not low while released");
    AST_OE_RELEASE: assert property (spi_cs_n [*6] |-> spi_miso_oe_n)
        else $error("miso still driven after deselect");

    // latch set only by a command inside a frame, cleared at end of write
    AST_LATCH_IN_FRAME: assert property ($rose(write_permit_latch) |-> !$past(spi_cs_n, 3))
        else $error("latch set outside a frame");
    AST_LATCH_CLEAR: assert property ($fell(array_busy) |-> ##[1:2] !write_permit_latch)
        else $error("latch not cleared after write end");

    // main scenarios reached
    COV_REFUSED: cover property (pready && pslverr);
    COV_LATCH: cover property ($rose(write_permit_latch));
    COV_IRQ: cover property ($rose(irq));
    COV_MISO: cover property (!spi_miso_oe_n);
endmodule

bind smp_top smp_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .spi_cs_n(spi_cs_n),
    .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .array_busy(array_busy),
    .write_permit_latch(write_permit_latch), .irq(irq));
`default_nettype wire

// *** dv/smp_host_model.sv ***
// host controller model driving the serial flash pins of the block
`timescale 1ns/10ps
`default_nettype none
module smp_host_model
(
    // host driven pins
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    // device driven pins
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe_n
);
    // idle: clock stopped low, select high
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // mode 0 frame, bytes right aligned, msb first; an undriven miso reads as unknown
    task automatic xfer(input logic [55:0] tx, input int nb, output logic [55:0] rx);
        rx = 'x;
        #7 spi_cs_n = 1'b0;
        for (int i = nb * 8 - 1; i >= 0; i--)
        begin
            spi_mosi = tx[i];
            #80 spi_sclk = 1'b1;
            rx[i] = (spi_miso_oe_n === 1'b0) ? spi_miso : 1'bx;
            #80 spi_sclk = 1'b0;
        end
        #80 spi_cs_n = 1'b1;
        // released line shows a changed value, not the last bit
        spi_mosi = ~spi_mosi;
        #320;
    endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the status map parameter table block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, x, m) begin comparisons++; if ((g) !== (x)) begin err_total++; $display("FAIL t=%0t %s", $time, m); end end
module tb
    import smp_pkg::*;
;
    // bench signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
    logic        array_busy, array_prog_fail, write_permit_latch, irq;
    logic [55:0] rx;
    int          err_total, comparisons;
    // table bytes in index order, first byte in the top lane; packed so every simulator takes it
    localparam logic [71:0] TBL = 72'h90_06_05_00_A1_00_65_00_96;

    smp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n), .array_busy(array_busy), .array_prog_fail(array_prog_fail),
        .write_permit_latch(write_permit_latch), .irq(irq));
    smp_host_model host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n));

    // 100 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // apb transfer; held until pready is seen at a rising edge, bounded wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        `CHK(pready, 1'b1, "no pready")
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        `CHK(e, xe, "write response")
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(e, xe, "read response")
        if (!xe)
            `CHK(r, x, "read data")
    endtask

    // last two bytes of a frame both carry the expected status byte
    task automatic sr(input logic [55:0] tx, input int nb, input logic [7:0] x);
        logic [55:0] r;
        host.xfer(tx, nb, r);
        `CHK(r[15:0], {x, x}, "serial status byte")
    endtask

    // hang guard, well beyond the expected run
    initial
    begin
        #400000;
        `CHK(1'b0, 1'b1, "watchdog")
        end_sim();
    end

    initial
    begin
        logic [9:0] ix;
        err_total = 0;
        comparisons = 0;
        {presetn, psel, penable, pwrite, array_busy, array_prog_fail} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        cyc(2);
        `CHK({write_permit_latch, irq, spi_miso_oe_n}, 3'h1, "reset levels")
        // whole descriptor table, then a refused write leaves it intact
        for (int i = 0; i < 9; i++)
        begin
            ix = PROGRESS_FLAG_DESCRIPTOR_IDX + 10'(i);
            rd({ix, 2'b00}, {24'h0, TBL[8*(8-i) +: 8]}, 1'b0);
        end
        wr(12'h600, 32'h000000FF, 1'b1);
        rd(12'h600, 32'h00000006, 1'b0);
        // unmapped, misaligned and read-only places refused
        rd(12'h00C, 32'h0, 1'b1);
        rd(12'h002, 32'h0, 1'b1);
        wr(FLAG_STATE_OFS, 32'h0, 1'b1);
        wr(EVT_MASK_OFS, 32'h7, 1'b0);
        rd(EVT_MASK_OFS, 32'h7, 1'b0);
        // internal write running shows at bit 0
        array_busy <= 1'b1;
        cyc(4);
        sr(56'h050000, 3, 8'h01);
        rd(FLAG_STATE_OFS, 32'h01, 1'b0);
        // unknown opcode with a would-be status write changes nothing
        host.xfer(56'h01FF, 2, rx);
        sr(56'h050000, 3, 8'h01);
        // direct command sets the latch at bit 1 and raises the event
        host.xfer(56'h06, 1, rx);
        cyc(4);
        `CHK(write_permit_latch, 1'b1, "latch set")
        sr(56'h050000, 3, 8'h03);
        `CHK(irq, 1'b1, "irq on latch event")
        rd(EVT_STATUS_OFS, 32'h1, 1'b0);
        // program error at bit 6 through the addressed read
        array_prog_fail <= 1'b1;
        cyc(4);
        sr(56'h65000000000000, 7, 8'h43);
        sr(56'h65000001000000, 7, 8'h00);
        // end of the internal write
        array_busy <= 1'b0;
        cyc(4);
        `CHK(write_permit_latch, 1'b0, "latch clear")
        rd(FLAG_STATE_OFS, 32'h40, 1'b0);
        rd(EVT_STATUS_OFS, 32'h7, 1'b0);
        wr(EVT_STATUS_OFS, 32'h7, 1'b0);
        rd(EVT_STATUS_OFS, 32'h0, 1'b0);
        cyc(2);
        `CHK(irq, 1'b0, "irq cleared")
        // masked event stays silent until unmasked
        wr(EVT_MASK_OFS, 32'h0, 1'b0);
        array_prog_fail <= 1'b0;
        cyc(2);
        array_prog_fail <= 1'b1;
        cyc(4);
        `CHK(irq, 1'b0, "masked irq")
        rd(EVT_STATUS_OFS, 32'h4, 1'b0);
        wr(EVT_MASK_OFS, 32'h4, 1'b0);
        cyc(2);
        `CHK(irq, 1'b1, "unmasked irq")
        end_sim();
    end
endmodule
`default_nettype wire
